// >>> usart_pkg.sv
`default_nettype none
package usart_pkg;
  // control/data select values
  localparam logic       SEL_DATA = 1'h0;
  localparam logic       SEL_CTRL = 1'h1;
  // mode word fields
  localparam int         M_FACT_LSB = 0;
  localparam int         M_FACT_MSB = 1;
  localparam int         M_LEN_LSB  = 2;
  localparam int         M_LEN_MSB  = 3;
  localparam int         M_PAR_EN   = 4;
  localparam int         M_PAR_EVEN = 5;
  localparam int         M_EXT_SYNC = 6;
  localparam int         M_ONE_SYNC = 7;
  localparam int         M_STOP_LSB = 6;
  localparam int         M_STOP_MSB = 7;
  localparam logic [1:0] FACT_SYNC  = 2'h0;
  localparam logic [1:0] FACT_1X    = 2'h1;
  localparam logic [1:0] FACT_16X   = 2'h2;
  localparam logic [1:0] STOP_ONE   = 2'h1;
  localparam logic [1:0] STOP_HALF  = 2'h2;
  localparam logic [6:0] DIV_1X     = 7'h01;
  localparam logic [6:0] DIV_16X    = 7'h10;
  localparam logic [6:0] DIV_64X    = 7'h40;
  localparam logic [3:0] LEN_BASE   = 4'h5;
  localparam logic [3:0] LEN_MAX    = 4'h8;
  // command word fields
  localparam int         C_TX_EN    = 0;
  localparam int         C_RX_EN    = 2;
  localparam int         C_BREAK    = 3;
  localparam int         C_ERR_RST  = 4;
  localparam int         C_INT_RST  = 6;
  localparam int         C_HUNT     = 7;
  // status word fields
  localparam int         S_TX_RDY   = 0;
  localparam int         S_RX_RDY   = 1;
  localparam int         S_TX_EMPTY = 2;
  localparam int         S_PE       = 3;
  localparam int         S_OE       = 4;
  localparam int         S_FE       = 5;
  localparam int         S_SYNC_DETECT_PIN   = 6;
  localparam int         S_SPARE    = 7;
  typedef enum logic [3:0] {
    PH_MODE  = 4'h1,
    PH_SYNC1 = 4'h2,
    PH_SYNC2 = 4'h4,
    PH_CMD   = 4'h8
  } phase_t;
  typedef enum logic [5:0] {
    RX_IDLE  = 6'h01,
    RX_START = 6'h02,
    RX_BITS  = 6'h04,
    RX_STOP  = 6'h08,
    RX_HUNT  = 6'h10,
    RX_HUNT2 = 6'h20
  } rx_state_t;
endpackage : usart_pkg
`default_nettype wire

// >>> serial_unit.sv
// Our own choices: the address map and the plain strobed port.
`default_nettype none
module serial_unit (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       c_d,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       cts_n,
  input  wire logic       tx_bit_clock,
  input  wire logic       rx_bit_clock,
  input  wire logic       rx_serial,
  input  wire logic       sync_detect_in,
  output logic            tx_serial,
  output logic            tx_ready_flag,
  output logic            tx_empty_flag,
  output logic            rx_ready_flag,
  output logic            sync_detect_out,
  output logic            sync_detect_oe
);

  typedef struct packed {
    usart_pkg::phase_t    phase;
    logic [7:0]           mode;
    logic [7:0]           cmd;
    logic [7:0]           sync1;
    logic [7:0]           sync2;
    logic [7:0]           rdata;
    logic                 txc_q;
    logic [7:0]           hold;
    logic                 hold_full;
    logic [11:0]          tx_sh;
    logic [3:0]           tx_left;
    logic [6:0]           tx_cnt;
    logic                 tx_busy;
    logic                 tx_empty;
    logic                 tx_bit;
    logic                 tx_line;
    logic                 tx_started;
    logic                 sync_idx;
    logic                 rxc_q;
    logic                 rxd_q;
    usart_pkg::rx_state_t rx_st;
    logic [6:0]           rx_cnt;
    logic [3:0]           rx_idx;
    logic [7:0]           rx_sh;
    logic                 rx_par;
    logic [7:0]           rx_buf;
    logic                 rx_rdy;
    logic                 pe;
    logic                 oe;
    logic                 fe;
    logic                 sync_detect_pin;
  } st_t;

  st_t        st;
  st_t        next_st;
  logic [3:0] len;
  logic [6:0] period;
  logic [6:0] half;
  logic [7:0] len_mask;
  logic [7:0] status;
  logic [3:0] nbits;
  logic       is_sync;
  logic       ext_sync;
  logic       one_sync;
  logic       par_en;
  logic       odd;
  logic       stop_half;
  logic       can_send;
  logic       tx_tick;
  logic       rx_tick;
  logic       data_wr;
  logic       ctrl_wr;
  logic       data_rd;
  logic       stat_rd;
  logic       rx_load;
  logic       hunt_hit;
  logic       filler;

  function automatic logic [6:0] period_of(input logic [7:0] m);
    case (m[usart_pkg::M_FACT_MSB:usart_pkg::M_FACT_LSB])
      usart_pkg::FACT_16X: period_of = usart_pkg::DIV_16X;
      usart_pkg::FACT_SYNC,
      usart_pkg::FACT_1X:  period_of = usart_pkg::DIV_1X;
      default:             period_of = usart_pkg::DIV_64X;
    endcase
  endfunction : period_of

  function automatic logic par_of(input logic [7:0] d, input logic [3:0] n, input logic o);
    logic p;
    p = o;
    for (int i = 0; i < 8; i++)
      if (i < int'(n))
        p = p ^ d[i];
    return p;
  endfunction : par_of

  // sync frames carry no start or stop bits, so data starts at bit zero
  function automatic logic [11:0] tx_frame(input logic [7:0] d, input logic [3:0] n,
                                           input logic sy, input logic pen, input logic o);
    logic [11:0] f;
    int          s;
    f = '1;
    s = sy ? 0 : 1;
    if (!sy)
      f[0] = 1'h0;
    for (int i = 0; i < 8; i++)
      if (i < int'(n))
        f[s + i] = d[i];
    if (pen)
      f[s + int'(n)] = par_of(d, n, o);
    return f;
  endfunction : tx_frame

  assign len       = usart_pkg::LEN_BASE
                     + {2'h0, st.mode[usart_pkg::M_LEN_MSB:usart_pkg::M_LEN_LSB]};
  assign period    = period_of(st.mode);
  assign half      = period >> 1;
  assign len_mask  = 8'hff >> (usart_pkg::LEN_MAX - len);
  assign is_sync   = st.mode[usart_pkg::M_FACT_MSB:usart_pkg::M_FACT_LSB] == usart_pkg::FACT_SYNC;
  assign ext_sync  = st.mode[usart_pkg::M_EXT_SYNC];
  assign one_sync  = st.mode[usart_pkg::M_ONE_SYNC];
  assign par_en    = st.mode[usart_pkg::M_PAR_EN];
  assign odd       = !st.mode[usart_pkg::M_PAR_EVEN];
  assign stop_half = st.mode[usart_pkg::M_STOP_MSB:usart_pkg::M_STOP_LSB] == usart_pkg::STOP_HALF;
  assign nbits     = is_sync ? len + {3'h0, par_en}
                     : len + {3'h0, par_en} + ((st.mode[usart_pkg::M_STOP_MSB:usart_pkg::M_STOP_LSB]
                       == usart_pkg::STOP_ONE) ? 4'h2 : 4'h3);
  assign data_wr   = wr && c_d == usart_pkg::SEL_DATA;
  assign ctrl_wr   = wr && c_d == usart_pkg::SEL_CTRL;
  assign data_rd   = rd && c_d == usart_pkg::SEL_DATA;
  assign stat_rd   = rd && c_d == usart_pkg::SEL_CTRL;
  assign can_send  = st.phase == usart_pkg::PH_CMD && st.cmd[usart_pkg::C_TX_EN] && !cts_n;
  assign tx_tick   = st.txc_q && !tx_bit_clock;
  assign rx_tick   = !st.rxc_q && rx_bit_clock;

  always_comb
  begin
    status                       = '0;
    status[usart_pkg::S_TX_RDY]  = !st.hold_full;
    status[usart_pkg::S_RX_RDY]  = st.rx_rdy;
    status[usart_pkg::S_TX_EMPTY] = st.tx_empty;
    status[usart_pkg::S_PE]      = st.pe;
    status[usart_pkg::S_OE]      = st.oe;
    status[usart_pkg::S_FE]      = st.fe;
    status[usart_pkg::S_SYNC_DETECT_PIN]  = st.sync_detect_pin;
    status[usart_pkg::S_SPARE]   = 1'h0;
  end

  always_comb
  begin
    logic [6:0] bit_len;
    logic       fin;
    next_st  = st;
    rx_load  = 1'h0;
    hunt_hit = 1'h0;
    filler   = 1'h0;
    fin      = 1'h0;
    bit_len  = (st.tx_left == 4'h1 && stop_half && !is_sync) ? half : period;
    next_st.txc_q = tx_bit_clock;
    next_st.rxc_q = rx_bit_clock;
    // clears come first so that a same-cycle hardware event wins; the internal reset is applied last and overrides all of it
    if (data_wr)
    begin
      next_st.hold      = wdata;
      next_st.hold_full = 1'h1;
      next_st.tx_empty  = 1'h0;
    end
    if (data_rd)
    begin
      next_st.rdata  = st.rx_buf;
      next_st.rx_rdy = 1'h0;
    end
    if (stat_rd)
    begin
      next_st.rdata  = status;
      next_st.sync_detect_pin = 1'h0;
    end
    if (ctrl_wr)
      case (st.phase)
        usart_pkg::PH_MODE:
        begin
          next_st.mode  = wdata;
          next_st.phase = (wdata[usart_pkg::M_FACT_MSB:usart_pkg::M_FACT_LSB] == usart_pkg::FACT_SYNC)
                          ? usart_pkg::PH_SYNC1 : usart_pkg::PH_CMD;
        end
        usart_pkg::PH_SYNC1:
        begin
          next_st.sync1 = wdata;
          next_st.phase = one_sync ? usart_pkg::PH_CMD : usart_pkg::PH_SYNC2;
        end
        usart_pkg::PH_SYNC2:
        begin
          next_st.sync2 = wdata;
          next_st.phase = usart_pkg::PH_CMD;
        end
        default:
        begin
          next_st.cmd = wdata;
          if (wdata[usart_pkg::C_ERR_RST])
          begin
            next_st.pe = 1'h0;
            next_st.oe = 1'h0;
            next_st.fe = 1'h0;
          end
          if (wdata[usart_pkg::C_HUNT] && is_sync && !ext_sync)
          begin
            next_st.rx_st  = usart_pkg::RX_HUNT;
            next_st.rx_sh  = '0;
            next_st.rx_idx = '0;
          end
        end
      endcase
    // transmitter
    if (tx_tick)
    begin
      if (st.tx_busy)
      begin
        if (st.tx_cnt + 7'h01 >= bit_len)
        begin
          next_st.tx_cnt  = '0;
          next_st.tx_sh   = st.tx_sh >> 1;
          next_st.tx_left = st.tx_left - 4'h1;
          next_st.tx_bit  = st.tx_sh[1];
          fin             = st.tx_left == 4'h1;
        end
        else
          next_st.tx_cnt = st.tx_cnt + 7'h01;
      end
      if (!st.tx_busy || fin)
      begin
        if (can_send && st.hold_full)
        begin
          next_st.tx_sh      = tx_frame(st.hold, len, is_sync, par_en, odd);
          next_st.hold_full  = data_wr;
          next_st.tx_started = is_sync;
        end
        else if (is_sync && st.tx_started && can_send)
        begin
          filler             = 1'h1;
          next_st.tx_sh      = tx_frame(st.sync_idx ? st.sync2 : st.sync1, len, 1'h1, par_en, odd);
          next_st.sync_idx   = !one_sync && !st.sync_idx;
          next_st.tx_empty   = 1'h1;
        end
        else
        begin
          next_st.tx_busy = 1'h0;
          next_st.tx_bit  = 1'h1;
          if (fin)
            next_st.tx_empty = 1'h1;
        end
        if (next_st.tx_sh != st.tx_sh >> 1 || !fin || filler)
          if (filler || (can_send && st.hold_full))
          begin
            next_st.tx_bit  = next_st.tx_sh[0];
            next_st.tx_left = nbits;
            next_st.tx_cnt  = '0;
            next_st.tx_busy = 1'h1;
          end
      end
    end
    next_st.tx_line = next_st.tx_bit && !st.cmd[usart_pkg::C_BREAK];
    // receiver, sampled on rising bit clock edges
    if (rx_tick)
    begin
      next_st.rxd_q = rx_serial;
      case (st.rx_st)
        usart_pkg::RX_IDLE:
          if (!is_sync && st.rxd_q && !rx_serial)
          begin
            next_st.rx_cnt = '0;
            next_st.rx_idx = '0;
            next_st.rx_sh  = '0;
            next_st.rx_st  = (period == usart_pkg::DIV_1X) ? usart_pkg::RX_BITS : usart_pkg::RX_START;
          end
          else if (is_sync && ext_sync && sync_detect_in)
          begin
            next_st.rx_idx = '0;
            next_st.rx_sh  = '0;
            next_st.rx_st  = usart_pkg::RX_BITS;
          end
        usart_pkg::RX_START:
          if (st.rx_cnt + 7'h01 >= half)
          begin
            next_st.rx_cnt = '0;
            next_st.rx_st  = rx_serial ? usart_pkg::RX_IDLE : usart_pkg::RX_BITS;
          end
          else
            next_st.rx_cnt = st.rx_cnt + 7'h01;
        usart_pkg::RX_BITS:
          if (st.rx_cnt + 7'h01 >= period)
          begin
            next_st.rx_cnt = '0;
            if (st.rx_idx < len)
              next_st.rx_sh[st.rx_idx[2:0]] = rx_serial;
            else
              next_st.rx_par = rx_serial;
            next_st.rx_idx = st.rx_idx + 4'h1;
            if (st.rx_idx + 4'h1 == len + {3'h0, par_en})
            begin
              next_st.rx_idx = '0;
              if (is_sync)
                rx_load = 1'h1;
              else
                next_st.rx_st = usart_pkg::RX_STOP;
            end
          end
          else
            next_st.rx_cnt = st.rx_cnt + 7'h01;
        usart_pkg::RX_STOP:
          if (st.rx_cnt + 7'h01 >= period)
          begin
            next_st.rx_cnt = '0;
            next_st.fe     = next_st.fe || !rx_serial;
            rx_load        = 1'h1;
            next_st.rx_st  = usart_pkg::RX_IDLE;
          end
          else
            next_st.rx_cnt = st.rx_cnt + 7'h01;
        usart_pkg::RX_HUNT:
        begin
          next_st.rx_sh = {rx_serial, st.rx_sh[7:1]};
          if ((next_st.rx_sh >> (usart_pkg::LEN_MAX - len)) == (st.sync1 & len_mask))
          begin
            if (one_sync)
              hunt_hit = 1'h1;
            else
            begin
              next_st.rx_st  = usart_pkg::RX_HUNT2;
              next_st.rx_idx = '0;
              next_st.rx_sh  = '0;
            end
          end
        end
        usart_pkg::RX_HUNT2:
        begin
          next_st.rx_sh[st.rx_idx[2:0]] = rx_serial;
          next_st.rx_idx                = st.rx_idx + 4'h1;
          if (st.rx_idx + 4'h1 == len)
          begin
            hunt_hit      = next_st.rx_sh == (st.sync2 & len_mask);
            next_st.rx_st = usart_pkg::RX_HUNT;
          end
        end
        default:
          next_st.rx_st = usart_pkg::RX_IDLE;
      endcase
    end
    if (hunt_hit)
    begin
      next_st.sync_detect_pin = 1'h1;
      next_st.rx_st  = usart_pkg::RX_BITS;
      next_st.rx_idx = '0;
      next_st.rx_sh  = '0;
      next_st.rx_cnt = '0;
    end
    // errors are recorded but never stop the receiver
    if (rx_load)
    begin
      next_st.rx_buf = next_st.rx_sh & len_mask;
      next_st.oe     = next_st.oe || next_st.rx_rdy;
      next_st.pe     = next_st.pe || (par_en
                       && next_st.rx_par != par_of(next_st.rx_sh, len, odd));
      next_st.rx_rdy = 1'h1;
      next_st.rx_sh  = '0;
    end
    if (!next_st.cmd[usart_pkg::C_RX_EN])
      next_st.rx_st = usart_pkg::RX_IDLE;
    if (ctrl_wr && st.phase == usart_pkg::PH_CMD && wdata[usart_pkg::C_INT_RST])
    begin
      next_st.phase      = usart_pkg::PH_MODE;
      next_st.cmd        = '0;
      next_st.hold_full  = 1'h0;
      next_st.tx_busy    = 1'h0;
      next_st.tx_bit     = 1'h1;
      next_st.tx_line    = 1'h1;
      next_st.tx_empty   = 1'h1;
      next_st.tx_started = 1'h0;
      next_st.sync_idx   = 1'h0;
      next_st.rx_st      = usart_pkg::RX_IDLE;
      next_st.rx_rdy     = 1'h0;
      next_st.sync_detect_pin     = 1'h0;
      next_st.pe         = 1'h0;
      next_st.oe         = 1'h0;
      next_st.fe         = 1'h0;
    end
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st          <= '0;
      st.phase    <= usart_pkg::PH_MODE;
      st.rx_st    <= usart_pkg::RX_IDLE;
      st.tx_bit   <= 1'h1;
      st.tx_line  <= 1'h1;
      st.tx_empty <= 1'h1;
      st.txc_q    <= 1'h1;
      st.rxd_q    <= 1'h1;
    end
    else
      st <= next_st;
  end

  assign rdata           = st.rdata;
  assign tx_serial       = st.tx_line;
  assign tx_ready_flag   = !st.hold_full && !cts_n && st.cmd[usart_pkg::C_TX_EN];
  assign tx_empty_flag   = st.tx_empty;
  assign rx_ready_flag   = st.rx_rdy;
  assign sync_detect_out = st.sync_detect_pin;
  assign sync_detect_oe  = is_sync && !ext_sync;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  a_tx_ready_flag_on_write: assert property (data_wr |=> st.hold_full && !tx_ready_flag)
    else $error("transmit ready not cleared by data write");
  a_rx_ready_flag_on_read: assert property (data_rd && !rx_load |=> !rx_ready_flag)
    else $error("receive ready not cleared by data read");
  a_overrun_set: assert property (rx_load && !data_rd && st.rx_rdy |=> st.oe && st.rx_rdy)
    else $error("overrun not flagged");
  a_send_gated: assert property (!can_send && !st.tx_busy |=> !st.tx_busy)
    else $error("transmission started while blocked");
  a_break_low: assert property (st.cmd[usart_pkg::C_BREAK] ##1 st.cmd[usart_pkg::C_BREAK]
                                |-> !tx_serial)
    else $error("break not driving output low");
  a_mode_marking: assert property (st.phase == usart_pkg::PH_MODE |-> tx_serial)
    else $error("output not marking before configuration");
  a_err_reset: assert property (ctrl_wr && st.phase == usart_pkg::PH_CMD
                                && wdata[usart_pkg::C_ERR_RST] && !rx_load
                                |=> !st.pe && !st.oe && !st.fe)
    else $error("error flags not cleared");
  a_int_reset: assert property (ctrl_wr && st.phase == usart_pkg::PH_CMD
                                && wdata[usart_pkg::C_INT_RST]
                                |=> st.phase == usart_pkg::PH_MODE ##1 st.cmd == '0)
    else $error("internal reset did not return to mode phase");
  a_sync_word_next: assert property (ctrl_wr && st.phase == usart_pkg::PH_MODE
                                     && wdata[usart_pkg::M_FACT_MSB:usart_pkg::M_FACT_LSB]
                                     == usart_pkg::FACT_SYNC
                                     |=> st.phase == usart_pkg::PH_SYNC1)
    else $error("sync mode word not followed by sync load");
  a_sync_detect_pin_hold: assert property (hunt_hit && !stat_rd |=> sync_detect_out
                                  && st.rx_st == usart_pkg::RX_BITS)
    else $error("sync detect not raised on hunt match");

  c_rx_char: cover property (rx_load ##[1:20] data_rd);
  c_filler: cover property (filler);
  c_hunt: cover property (hunt_hit);
  c_overrun: cover property (rx_load && st.rx_rdy);

endmodule : serial_unit
`default_nettype wire

// >>> serial_partner.sv
`default_nettype none
module serial_partner (
  input  wire logic tx_serial,
  output var logic  bclk,
  output var logic  rx_serial
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    bclk = 1'b1;
    rx_serial = 1'b1;
  end
  // baud generator runs free, shared by both directions
  always #20 bclk = ~bclk;
  // 16x async frame; the line marks between frames
  task send_frame(input logic [7:0] d, input logic stp, input int gap);
    logic [9:0] fr;
    fr = {stp, d, 1'b0};
    repeat (gap) @(negedge bclk);
    for (int i = 0; i < 10; i++)
    begin
      @(negedge bclk);
      rx_serial = fr[i];
      repeat (15) @(negedge bclk);
    end
    @(negedge bclk);
    rx_serial = 1'b1;
  endtask : send_frame
  // samples mid-bit, returns {stop, data, start}
  task recv_frame(output logic [9:0] fr);
    @(negedge tx_serial);
    repeat (8) @(posedge bclk);
    for (int i = 0; i < 10; i++)
    begin
      fr[i] = tx_serial;
      repeat (16) @(posedge bclk);
    end
  endtask : recv_frame
endmodule : serial_partner
`default_nettype wire

// >>> programmable_sync_async_serial_test.sv
`default_nettype none
module programmable_sync_async_serial_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic            clock = 1'b0;
  logic            sys_rst = 1'b1;
  logic            c_d = 1'b0;
  logic      [7:0] wdata = 8'h00;
  logic            wr = 1'b0;
  logic            rd = 1'b0;
  logic            cts_n = 1'b1;
  logic      [7:0] s;
  logic      [9:0] f;
  logic     [15:0] v;
  logic      [7:0] rows [4] = '{8'h55, 8'h00, 8'hff, 8'h81};
  int              miscompares = 0;
  int              cmp_count = 0;
  int              cycles = 0;
  wire logic [7:0] rdata;
  wire logic       txs, rxs, bclk, sd_out, sd_oe, sd_wire;
  wire logic       tx_ready_flag, tx_empty_flag, rx_ready_flag;
  // pin level: device drives only with its enable up
  assign sd_wire = sd_oe ? sd_out : 1'b0;
  always #5 clock = ~clock;
  serial_unit dut_u (
    .clock           (clock),
    .sys_rst         (sys_rst),
    .c_d             (c_d),
    .wdata           (wdata),
    .wr              (wr),
    .rd              (rd),
    .rdata           (rdata),
    .cts_n           (cts_n),
    .tx_bit_clock    (bclk),
    .rx_bit_clock    (bclk),
    .rx_serial       (rxs),
    .sync_detect_in  (sd_wire),
    .tx_serial       (txs),
    .tx_ready_flag   (tx_ready_flag),
    .tx_empty_flag   (tx_empty_flag),
    .rx_ready_flag   (rx_ready_flag),
    .sync_detect_out (sd_out),
    .sync_detect_oe  (sd_oe)
  );
  serial_partner partner_u (
    .tx_serial (txs),
    .bclk      (bclk),
    .rx_serial (rxs)
  );
  task give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  task chk(input logic [9:0] seen, input logic [9:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task put(input logic cd, input logic [7:0] d);
    @(posedge clock);
    c_d <= cd;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : put
  task get(input logic cd, output logic [7:0] d);
    @(posedge clock);
    c_d <= cd;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : get
  // whole run needs about 9000 cycles
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      miscompares++;
      give_verdict();
    end
  end
  initial
  begin
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    #1 chk({6'h0, txs, tx_empty_flag, rx_ready_flag, tx_ready_flag}, 10'h00c);
    put(1'b1, 8'h4e);
    put(1'b1, 8'h15);
    get(1'b1, s);
    chk({1'b0, tx_ready_flag, s}, 10'h005);
    put(1'b0, 8'ha5);
    repeat (200) @(posedge clock);
    chk({9'h0, txs}, 10'h001);
    cts_n <= 1'b0;
    partner_u.recv_frame(f);
    chk(f, {1'b1, 8'ha5, 1'b0});
    get(1'b0, s);
    $display("test setup done");
    foreach (rows[i])
    begin
      put(1'b0, rows[i]);
      #1 chk({9'h0, tx_ready_flag}, 10'h000);
      partner_u.recv_frame(f);
      chk(f, {1'b1, rows[i], 1'b0});
      chk({9'h0, tx_ready_flag}, 10'h001);
      partner_u.send_frame(rows[i], 1'b1, i * 7);
      chk({9'h0, rx_ready_flag}, 10'h001);
      get(1'b0, s);
      chk({2'h0, s}, {2'h0, rows[i]});
      #1 chk({9'h0, rx_ready_flag}, 10'h000);
      $display("test row %0d done", i);
    end
    // low stop bit on a frame left unread, then a second frame that overruns it
    partner_u.send_frame(8'h3c, 1'b0, 0);
    partner_u.send_frame(8'hc3, 1'b1, 2);
    get(1'b1, s);
    chk({2'h0, s & 8'h3a}, 10'h032);
    get(1'b0, s);
    chk({2'h0, s}, 10'h0c3);
    put(1'b1, 8'h15);
    get(1'b1, s);
    chk({2'h0, s & 8'h38}, 10'h000);
    $display("test errors done");
    put(1'b1, 8'h0d);
    repeat (100) @(posedge clock);
    chk({9'h0, txs}, 10'h000);
    put(1'b1, 8'h40);
    repeat (100) @(posedge clock);
    chk({9'h0, txs}, 10'h001);
    // 4e read as a command would cause another internal reset
    put(1'b1, 8'h4e);
    put(1'b1, 8'h05);
    put(1'b0, 8'h96);
    partner_u.recv_frame(f);
    chk(f, {1'b1, 8'h96, 1'b0});
    $display("test break and reset done");
    // no reset pin needed: three 00h words, then an internal reset
    repeat (3) put(1'b1, 8'h00);
    put(1'b1, 8'h40);
    put(1'b1, 8'h8c);
    put(1'b1, 8'h16);
    put(1'b1, 8'h01);
    repeat (40) @(posedge clock);
    chk({9'h0, txs}, 10'h001);
    chk({8'h0, sd_oe, sd_out}, 10'h002);
    put(1'b0, 8'h96);
    // one bit per bit clock; sample on the rising edge, mid-bit
    @(negedge txs);
    for (int i = 0; i < 16; i++)
    begin
      @(posedge bclk);
      v[i] = txs;
    end
    chk({2'h0, v[7:0]}, 10'h096);
    chk({2'h0, v[15:8]}, 10'h016);
    chk({9'h0, tx_empty_flag}, 10'h001);
    put(1'b0, 8'h5a);
    #1 chk({9'h0, tx_empty_flag}, 10'h000);
    $display("test sync transmit done");
    give_verdict();
  end
endmodule : programmable_sync_async_serial_test
`default_nettype wire
